/* hw/flgs_pkg.sv */
// Package for the fast level detect and gain switch block
package flgs_pkg;
  // Register byte addresses
  localparam logic [12:0] FLGS_ADDR_CTRL = 13'h0104;
  localparam logic [12:0] FLGS_ADDR_COARSE = 13'h0105;
  localparam logic [12:0] FLGS_ADDR_FHI_LO = 13'h0106;
  localparam logic [12:0] FLGS_ADDR_FHI_HI = 13'h0107;
  localparam logic [12:0] FLGS_ADDR_FLO_LO = 13'h0108;
  localparam logic [12:0] FLGS_ADDR_FLO_HI = 13'h0109;
  localparam logic [12:0] FLGS_ADDR_DWELL_LO = 13'h010a;
  localparam logic [12:0] FLGS_ADDR_DWELL_HI = 13'h010b;
  // Control register fields
  localparam int FLGS_CTRL_EN_BIT = 0;
  localparam int FLGS_CTRL_MODE_LSB = 1;
  localparam int FLGS_CTRL_MODE_W = 3;
  // Widths
  localparam int FLGS_MAG_W = 13;
  localparam int FLGS_COARSE_W = 3;
  localparam int FLGS_DWELL_W = 16;
  // Reset values
  localparam logic [7:0] FLGS_CTRL_RST = 8'h00;
  localparam logic [2:0] FLGS_COARSE_RST = 3'h0;
  localparam logic [12:0] FLGS_FHI_RST = 13'h1fff;
  localparam logic [12:0] FLGS_FLO_RST = 13'h0000;
  localparam logic [15:0] FLGS_DWELL_RST = 16'h0001;
  // Latencies in sample clocks, counted from the input of each path to the pins
  localparam int FLGS_LAT_FAST = 2;
  localparam int FLGS_LAT_SUBSET = 6;
  localparam int FLGS_LAT_PIPE = 12;
  localparam int FLGS_MIN_HOLD = 2;
  // Largest coarse code from the early stage
  localparam logic [3:0] FLGS_CODE_MAX = 4'h8;
  // Pin routing modes
  typedef enum logic [2:0] {
    FLGS_MODE_FULL_MAG = 3'h0,
    FLGS_MODE_MAG3_OVR = 3'h1,
    FLGS_MODE_MAG2_OVR_FLO = 3'h2,
    FLGS_MODE_MAG2_CHI_FLO = 3'h3,
    FLGS_MODE_FLAGS = 3'h4,
    FLGS_MODE_GAIN = 3'h5
  } flgs_mode_t;
endpackage

/* hw/flgs_delay.sv */
// Fixed shift-register delay line with every tap exposed
`timescale 1ns/1ps
module flgs_delay #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Data
  input wire logic [WIDTH-1:0] data_in,
  output logic [DEPTH*WIDTH-1:0] taps_out
);
  logic [WIDTH-1:0] stage_q [DEPTH];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          stage_q[i] <= '0;
        end else begin
          stage_q[i] <= (i == 0) ? data_in : stage_q[(i == 0) ? 0 : i-1];
        end
      end
      assign taps_out[i*WIDTH +: WIDTH] = stage_q[i];
    end
  endgenerate
endmodule // flgs_delay

/* hw/flgs_stretch.sv */
// Registers raw indicators and holds each high for a minimum number of cycles
`timescale 1ns/1ps
module flgs_stretch #(
  parameter int WIDTH = 1,
  parameter int MIN_HOLD = 2
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Indicators
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] held_out
);
  localparam int CW = $clog2(MIN_HOLD + 1);
  localparam logic [CW-1:0] HOLD_LOAD = CW'(MIN_HOLD - 1);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [CW-1:0] cnt_q;
      logic out_q;
      // Output follows the instantaneous level, the counter only extends short pulses
      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          out_q <= 1'b0;
          cnt_q <= '0;
        end else begin
          out_q <= raw_in[i] | (cnt_q != '0);
          if (raw_in[i] && !out_q) begin
            cnt_q <= HOLD_LOAD;
          end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
      end
      assign held_out[i] = out_q;
    end
  endgenerate
endmodule // flgs_stretch

/* hw/flgs_top.sv */
// Per-channel fast level detect and gain switch indicator logic
//
// Summary of operation
// - Mode zero: coarse code on pins, two cycles
// - Four-bit coarse code rises 0000 to 1000
// - Modes one to three: subset, six cycles
// - Mode one: three-bit code, top code saturates
// - Modes two, three: two-bit code, LSB dropped
// - Overrange shown twelve cycles after input
// - Coarse high flag two cycles after exceed, six in mode three
// - Coarse high flag held at least two cycles
// - Coarse trip code picks the level
// - Fine high flag: magnitude above fine high
// - Fine low flag: magnitude below fine low
// - Fine thresholds on thirteen-bit magnitude scale
// - Gain lower flag: fast magnitude above coarse
// - Gain raise flag after dwell below fine low
// - Instantaneous flags, each at least two cycles
// - Mode field routes the four pins
// - Comparisons use magnitude only, sign ignored
`timescale 1ns/1ps
module flgs_top
  import flgs_pkg::*;
#(
  parameter int SAMPLE_W = 10
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Converter datapath, same clock
  input wire logic [3:0] coarse_code_in,
  input wire logic ovr_in,
  input wire logic signed [SAMPLE_W-1:0] out_sample_in,
  // Register port from the serial control logic
  input wire logic [12:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Indicator pins
  output logic [3:0] level_indicator_pins_out
);
  // Registers
  logic [7:0] ctrl_q;
  logic [2:0] coarse_trip_level_q;
  logic [12:0] fine_high_trip_level_q;
  logic [12:0] fine_low_trip_level_q;
  logic [15:0] gain_raise_dwell_time_q;
  logic [7:0] rdata_q;
  logic [3:0] pins_q;
  logic [15:0] dwell_cnt_q;

  // Magnitude of a signed sample on the 13-bit full-scale scale
  function automatic logic [FLGS_MAG_W-1:0] mag13(input logic signed [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] a;
    logic [FLGS_MAG_W+SAMPLE_W-1:0] w;
    a = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
    w = (FLGS_MAG_W+SAMPLE_W)'(a) << (FLGS_MAG_W - (SAMPLE_W - 1));
    // Negative full scale would land on 2^13, saturate it to the top code
    mag13 = (w >= (FLGS_MAG_W+SAMPLE_W)'(1 << FLGS_MAG_W)) ? '1 : w[FLGS_MAG_W-1:0];
  endfunction

  // Clamp the nine-level early code to a three-bit code
  function automatic logic [2:0] code3(input logic [3:0] c);
    code3 = (c > 4'h7) ? 3'h7 : c[2:0];
  endfunction

  // Register writes
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_q <= FLGS_CTRL_RST;
      coarse_trip_level_q <= FLGS_COARSE_RST;
      fine_high_trip_level_q <= FLGS_FHI_RST;
      fine_low_trip_level_q <= FLGS_FLO_RST;
      gain_raise_dwell_time_q <= FLGS_DWELL_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        FLGS_ADDR_CTRL: begin
          ctrl_q <= {4'h0, reg_wdata_in[3:0]};
        end
        FLGS_ADDR_COARSE: begin
          coarse_trip_level_q <= reg_wdata_in[2:0];
        end
        FLGS_ADDR_FHI_LO: begin
          fine_high_trip_level_q[7:0] <= reg_wdata_in;
        end
        FLGS_ADDR_FHI_HI: begin
          fine_high_trip_level_q[12:8] <= reg_wdata_in[4:0];
        end
        FLGS_ADDR_FLO_LO: begin
          fine_low_trip_level_q[7:0] <= reg_wdata_in;
        end
        FLGS_ADDR_FLO_HI: begin
          fine_low_trip_level_q[12:8] <= reg_wdata_in[4:0];
        end
        FLGS_ADDR_DWELL_LO: begin
          gain_raise_dwell_time_q[7:0] <= reg_wdata_in;
        end
        FLGS_ADDR_DWELL_HI: begin
          gain_raise_dwell_time_q[15:8] <= reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  // Register reads, answered one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        FLGS_ADDR_CTRL: rdata_q <= ctrl_q;
        FLGS_ADDR_COARSE: rdata_q <= {5'h00, coarse_trip_level_q};
        FLGS_ADDR_FHI_LO: rdata_q <= fine_high_trip_level_q[7:0];
        FLGS_ADDR_FHI_HI: rdata_q <= {3'h0, fine_high_trip_level_q[12:8]};
        FLGS_ADDR_FLO_LO: rdata_q <= fine_low_trip_level_q[7:0];
        FLGS_ADDR_FLO_HI: rdata_q <= {3'h0, fine_low_trip_level_q[12:8]};
        FLGS_ADDR_DWELL_LO: rdata_q <= gain_raise_dwell_time_q[7:0];
        FLGS_ADDR_DWELL_HI: rdata_q <= gain_raise_dwell_time_q[15:8];
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_out = rdata_q;

  // Control fields
  logic detect_en;
  flgs_mode_t mode;
  assign detect_en = ctrl_q[FLGS_CTRL_EN_BIT];
  assign mode = flgs_mode_t'(ctrl_q[FLGS_CTRL_MODE_LSB +: FLGS_CTRL_MODE_W]);

  // Raw comparisons, all on unsigned magnitudes
  logic [FLGS_MAG_W-1:0] out_mag;
  logic [3:0] code_sat;
  logic chi_raw;
  logic fhi_raw;
  logic flo_raw;
  logic ihi_raw;
  logic [15:0] dwell_eff;
  assign code_sat = (coarse_code_in > FLGS_CODE_MAX) ? FLGS_CODE_MAX : coarse_code_in;
  assign out_mag = mag13(out_sample_in);
  assign chi_raw = code_sat > {1'b0, coarse_trip_level_q};
  assign fhi_raw = out_mag > fine_high_trip_level_q;
  assign flo_raw = out_mag < fine_low_trip_level_q;
  // A dwell of zero is outside the legal range and behaves as one
  assign dwell_eff = (gain_raise_dwell_time_q == 16'h0000) ? 16'h0001 : gain_raise_dwell_time_q;
  assign ihi_raw = flo_raw && (dwell_cnt_q >= dwell_eff - 16'h0001);

  // Consecutive cycles below the fine low level, saturating
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dwell_cnt_q <= 16'h0000;
    end else if (!flo_raw) begin
      dwell_cnt_q <= 16'h0000;
    end else if (dwell_cnt_q != 16'hffff) begin
      dwell_cnt_q <= dwell_cnt_q + 16'h0001;
    end
  end

  // Indicators are registered once and held for the minimum time
  // Bit order: 0 coarse high, 1 fine high, 2 fine low, 3 gain raise
  logic [3:0] flags;
  flgs_stretch #(
    .WIDTH(4),
    .MIN_HOLD(FLGS_MIN_HOLD)
  ) u_stretch (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .raw_in({ihi_raw, flo_raw, fhi_raw, chi_raw}),
    .held_out(flags)
  );

  // Early code delay; tap k holds the code from k+1 cycles ago
  localparam int CODE_DEPTH = FLGS_LAT_SUBSET - 1;
  logic [CODE_DEPTH*4-1:0] code_taps;
  flgs_delay #(
    .WIDTH(4),
    .DEPTH(CODE_DEPTH)
  ) u_code_dly (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .data_in(code_sat),
    .taps_out(code_taps)
  );

  // Flags delayed so that subset modes line up at six cycles
  localparam int FLAG_DEPTH = FLGS_LAT_SUBSET - FLGS_LAT_FAST;
  logic [FLAG_DEPTH*4-1:0] flag_taps;
  flgs_delay #(
    .WIDTH(4),
    .DEPTH(FLAG_DEPTH)
  ) u_flag_dly (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .data_in(flags),
    .taps_out(flag_taps)
  );

  // Overrange travels the full pipeline depth
  localparam int OVR_DEPTH = FLGS_LAT_PIPE - 1;
  logic [OVR_DEPTH-1:0] ovr_taps;
  flgs_delay #(
    .WIDTH(1),
    .DEPTH(OVR_DEPTH)
  ) u_ovr_dly (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .data_in(ovr_in),
    .taps_out(ovr_taps)
  );

  logic [3:0] code_fast;
  logic [3:0] code_slow;
  logic [2:0] code_slow3;
  logic [3:0] flag_slow;
  logic ovr_late;
  assign code_fast = code_taps[(FLGS_LAT_FAST-2)*4 +: 4];
  assign code_slow = code_taps[(FLGS_LAT_SUBSET-2)*4 +: 4];
  assign code_slow3 = code3(code_slow);
  assign flag_slow = flag_taps[(FLAG_DEPTH-1)*4 +: 4];
  assign ovr_late = ovr_taps[OVR_DEPTH-1];

  // Pin routing; the final register is the last stage of every latency
  logic [3:0] pins_d;
  always_comb begin
    pins_d = 4'h0;
    if (detect_en) begin
      case (mode)
        FLGS_MODE_FULL_MAG: begin
          pins_d = code_fast;
        end
        FLGS_MODE_MAG3_OVR: begin
          pins_d = {code_slow3, ovr_late};
        end
        FLGS_MODE_MAG2_OVR_FLO: begin
          pins_d = {code_slow3[2:1], ovr_late, flag_slow[2]};
        end
        FLGS_MODE_MAG2_CHI_FLO: begin
          pins_d = {code_slow3[2:1], flag_slow[0], flag_slow[2]};
        end
        FLGS_MODE_FLAGS: begin
          pins_d = {ovr_late, flags[0], flags[1], flags[2]};
        end
        FLGS_MODE_GAIN: begin
          // Gain lower shares the coarse high comparison and its hold
          pins_d = {ovr_late, flags[1], flags[3], flags[0]};
        end
        default: begin
          pins_d = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pins_q <= 4'h0;
    end else begin
      pins_q <= pins_d;
    end
  end
  assign level_indicator_pins_out = pins_q;
endmodule // flgs_top

/* verification/flgs_agc_model.sv */
// Behavioural model of the external gain controller
`timescale 1ns/1ps
module flgs_agc_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Indicator pins
  input wire logic [3:0] pins_in,
  // Attenuator command
  output logic atten_out
);
  logic atten_q;
  assign atten_out = atten_q;
  // Samples every edge; assumes the gain routing, so other modes give a meaningless command
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      atten_q <= 1'b0;
    end else if (pins_in[0]) begin
      atten_q <= 1'b1;
    end else if (pins_in[1]) begin
      atten_q <= 1'b0;
    end
  end
endmodule // flgs_agc_model

/* verification/flgs_top_chk.sv */
// Checker for the indicator pins of the level detect block
`timescale 1ns/1ps
module flgs_chk #(
  parameter int SAMPLE_W = 10
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [3:0] coarse_code_in,
  input wire logic ovr_in,
  input wire logic signed [SAMPLE_W-1:0] out_sample_in,
  input wire logic [12:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [3:0] level_indicator_pins_out
);
  logic [3:0] ctl_q;
  logic [2:0] trip_q;
  logic [12:0] fhi_q;
  logic [12:0] flo_q;
  logic [3:0] age_q;
  logic st;
  logic [2:0] md;
  logic [3:0] p;
  assign p = level_indicator_pins_out;
  // Age gates every check so a mode or level change never mixes old and new pipeline contents
  assign st = ctl_q[0] && (age_q >= 4'hd);
  assign md = ctl_q[3:1];
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl_q <= 4'h0;
      trip_q <= 3'h0;
      fhi_q <= 13'h1fff;
      flo_q <= 13'h0000;
      age_q <= 4'h0;
    end else if (reg_wr_in) begin
      age_q <= 4'h0;
      case (reg_addr_in)
        13'h0104: ctl_q <= reg_wdata_in[3:0];
        13'h0105: trip_q <= reg_wdata_in[2:0];
        13'h0106: fhi_q[7:0] <= reg_wdata_in;
        13'h0107: fhi_q[12:8] <= reg_wdata_in[4:0];
        13'h0108: flo_q[7:0] <= reg_wdata_in;
        13'h0109: flo_q[12:8] <= reg_wdata_in[4:0];
        default: ;
      endcase
    end else if (age_q != 4'hf) begin
      age_q <= age_q + 4'h1;
    end
  end
  function automatic logic [3:0] c8(input logic [3:0] c);
    return (c > 4'h8) ? 4'h8 : c;
  endfunction
  function automatic logic [2:0] c7(input logic [3:0] c);
    return (c > 4'h7) ? 3'h7 : c[2:0];
  endfunction
  function automatic logic [12:0] mag(input logic signed [SAMPLE_W-1:0] s);
    logic [12:0] a;
    a = 13'(s < 0 ? -s : s);
    if (s[SAMPLE_W-1] && s[SAMPLE_W-2:0] == '0) return 13'h1fff;
    return a << (14 - SAMPLE_W);
  endfunction
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence cut_rise;
    st && md == 3'h4 && $rose(p[2]);
  endsequence
  sequence cut_quiet;
    (st && md == 3'h4 && !($past(coarse_code_in, 2) > trip_q)) [*2];
  endsequence
  AST_FULL_MAG: assert property (st && md == 3'h0 |-> p == c8($past(coarse_code_in, 2)))
    else $error("mode 0 pins wrong");
  AST_MAG3: assert property (st && md == 3'h1 |-> p == {c7($past(coarse_code_in, 6)), $past(ovr_in, 12)})
    else $error("mode 1 pins wrong");
  AST_MAG2: assert property (st && md inside {3'h2, 3'h3} |-> {1'b0, p[3:2]} == c7($past(coarse_code_in, 6)) >> 1)
    else $error("mode 2 or 3 code wrong");
  AST_OFF: assert property (!ctl_q[0] && age_q >= 4'h2 |-> p == 4'h0)
    else $error("disabled pins not low");
  AST_CUT_HOLD: assert property (cut_rise |=> p[2])
    else $error("coarse flag too short");
  AST_CUT_CLEAR: assert property (cut_quiet |-> !p[2])
    else $error("coarse flag stuck high");
  AST_FHI: assert property (st && md == 3'h4 && mag($past(out_sample_in, 2)) > fhi_q |-> p[1])
    else $error("fine high flag missing");
  AST_FLO: assert property (st && md == 3'h4 && mag($past(out_sample_in, 2)) < flo_q |-> p[0])
    else $error("fine low flag missing");
  AST_DG: assert property (st && md == 3'h5 && $past(coarse_code_in, 2) > trip_q |-> p[0])
    else $error("gain lower flag missing");
endmodule // flgs_chk
bind flgs_top flgs_chk #(.SAMPLE_W(SAMPLE_W)) u_flgs_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .coarse_code_in(coarse_code_in), .ovr_in(ovr_in), .out_sample_in(out_sample_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .level_indicator_pins_out(level_indicator_pins_out));

/* verification/test_fast_level_detect_gain_switch.sv */
// Self-checking bench for the level detect and gain switch block
`timescale 1ns/1ps
module test_fast_level_detect_gain_switch;
  typedef struct {logic [12:0] a; logic w; logic [7:0] d; logic [7:0] e;} flgs_reg_row_t;
  typedef struct {logic [7:0] c; logic [3:0] k; logic o; logic [9:0] s; logic [3:0] e;} flgs_pin_row_t;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] code = 4'h0;
  logic ovr = 1'b0;
  logic signed [9:0] smp = 10'h000;
  logic [12:0] addr = 13'h0000;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [3:0] pins;
  logic atten;
  int failures = 0;
  int compares = 0;
  flgs_reg_row_t rr[13] = '{'{13'h0104, 1'b0, 8'h00, 8'h00}, '{13'h0105, 1'b0, 8'h00, 8'h00},
    '{13'h0106, 1'b0, 8'h00, 8'hff}, '{13'h0107, 1'b0, 8'h00, 8'h1f}, '{13'h0108, 1'b0, 8'h00, 8'h00},
    '{13'h0109, 1'b0, 8'h00, 8'h00}, '{13'h010a, 1'b0, 8'h00, 8'h01}, '{13'h010b, 1'b0, 8'h00, 8'h00},
    '{13'h0100, 1'b0, 8'h00, 8'h00}, '{13'h0105, 1'b1, 8'hff, 8'h07}, '{13'h0107, 1'b1, 8'hff, 8'h1f},
    '{13'h010c, 1'b1, 8'hff, 8'h00}, '{13'h0104, 1'b1, 8'hf0, 8'h00}};
  flgs_pin_row_t pr[15] = '{'{8'h01, 4'h5, 1'b0, 10'h000, 4'h5}, '{8'h01, 4'h9, 1'b0, 10'h000, 4'h8},
    '{8'h03, 4'h8, 1'b1, 10'h000, 4'hf}, '{8'h03, 4'h2, 1'b0, 10'h000, 4'h4}, '{8'h05, 4'h5, 1'b1, 10'h00a, 4'hb},
    '{8'h07, 4'h4, 1'b0, 10'h064, 4'ha}, '{8'h09, 4'h2, 1'b1, 10'h2d4, 4'ha}, '{8'h09, 4'h4, 1'b0, 10'h00a, 4'h5},
    '{8'h09, 4'h0, 1'b0, 10'h100, 4'h0}, '{8'h09, 4'h0, 1'b0, 10'h200, 4'h2}, '{8'h0b, 4'h7, 1'b0, 10'h12c, 4'h5},
    '{8'h0b, 4'h0, 1'b0, 10'h00a, 4'h2}, '{8'h0d, 4'h7, 1'b1, 10'h12c, 4'h0}, '{8'h0f, 4'h7, 1'b1, 10'h12c, 4'h0},
    '{8'h08, 4'h7, 1'b1, 10'h12c, 4'h0}};
  flgs_top #(.SAMPLE_W(10)) u_flgs_top (.mclk_in(mclk_in), .resetn_in(resetn_in), .coarse_code_in(code),
    .ovr_in(ovr), .out_sample_in(smp), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .level_indicator_pins_out(pins));
  flgs_agc_model u_flgs_agc_model (.mclk_in(mclk_in), .resetn_in(resetn_in), .pins_in(pins), .atten_out(atten));
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic wrap_up();
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: read %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: pins %b not %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic wreg(input logic [12:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    // Idle cycle so back-to-back writes never reassign the strobe in one step
    cyc(1);
  endtask
  // Extra cycle before the compare keeps it clear of the read edge
  task automatic rreg(input logic [12:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    chk8(rdata, e);
  endtask
  initial begin
    #50000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    resetn_in = 1'b1;
    cyc(1);
    foreach (rr[i]) begin
      if (rr[i].w) begin
        wreg(rr[i].a, rr[i].d);
      end
      rreg(rr[i].a, rr[i].e);
    end
    wreg(13'h0105, 8'h03);
    wreg(13'h0106, 8'h00);
    wreg(13'h0107, 8'h10);
    wreg(13'h0109, 8'h01);
    foreach (pr[i]) begin
      code = pr[i].k;
      ovr = pr[i].o;
      smp = pr[i].s;
      wreg(13'h0104, pr[i].c);
      cyc(14);
      chk4(pins, pr[i].e);
    end
    code = 4'h0;
    ovr = 1'b0;
    smp = 10'h064;
    wreg(13'h0104, 8'h09);
    cyc(14);
    code = 4'h4;
    cyc(1);
    code = 4'h0;
    cyc(1);
    chk4(pins, 4'h4);
    cyc(1);
    chk4(pins, 4'h4);
    cyc(1);
    chk4(pins, 4'h0);
    wreg(13'h010a, 8'h05);
    wreg(13'h0104, 8'h0b);
    cyc(14);
    // Gain lower pulse must make the controller insert the attenuator
    code = 4'h4;
    cyc(3);
    chk4({3'h0, atten}, 4'h1);
    code = 4'h0;
    cyc(3);
    for (int j = 0; j < 2; j++) begin
      smp = 10'h00a;
      cyc(5);
      chk4(pins, 4'h0);
      cyc(1);
      chk4(pins, 4'h2);
      smp = 10'h064;
      cyc(1);
    end
    chk4({3'h0, atten}, 4'h0);
    resetn_in = 1'b0;
    cyc(1);
    chk4(pins, 4'h0);
    resetn_in = 1'b1;
    cyc(1);
    rreg(13'h0104, 8'h00);
    rreg(13'h010a, 8'h01);
    wrap_up();
  end
endmodule // test_fast_level_detect_gain_switch
